/* rtl/tam_status_regs.sv */
`timescale 1ns/1ps
module tam_status_regs
  import tam_pkg::*;
#(
  parameter int NUM_CH = 3,
  parameter logic [7:0] MAKER_ID = MAKER_ID_DEFAULT,
  parameter logic [7:0] PART_ID = PART_ID_DEFAULT
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // pointer register access
  input wire tam_reg_req_t regReq,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // conversion results, same clock domain
  input wire logic convDone,
  input wire tam_chan_t [NUM_CH-1:0] chanIn,
  // alarm outputs and summary flags
  output logic alertActive,
  output logic thermActive,
  output logic highFlag,
  output logic lowFlag,
  output logic thermFlag
);

  // number of consecutive conversions a count code asks for
  function automatic logic [2:0] countNeed(input logic [2:0] code);
    countNeed = 3'(code[0]) + 3'(code[1]) + 3'(code[2]) + 3'h1;
  endfunction : countNeed

  // the local channel has no diode, so its open bit stays zero
  localparam logic [NUM_CH-1:0] OPEN_VALID = {{(NUM_CH-1){1'b1}}, 1'b0};

  // stored registers, sticky flags and run state
  logic [7:0] shutdownHysteresis;
  logic [7:0] consecutiveFaultFilter;
  logic [NUM_CH-1:0] chanMask;
  logic [NUM_CH-1:0] diodeOpenFlags;
  logic [NUM_CH-1:0] highFlags;
  logic [NUM_CH-1:0] lowFlags;
  logic [NUM_CH-1:0] shutFlags;
  logic [NUM_CH-1:0] lastHigh;
  logic [NUM_CH-1:0] lastLow;
  logic [NUM_CH-1:0] lastOpen;
  logic [NUM_CH-1:0] shutTrip;
  logic [2:0] alarmRun [NUM_CH];
  logic [2:0] shutRun [NUM_CH];

  // next values and the current comparator view
  logic [NUM_CH-1:0] next_shutTrip;
  logic [NUM_CH-1:0] next_diodeOpenFlags;
  logic [NUM_CH-1:0] next_highFlags;
  logic [NUM_CH-1:0] next_lowFlags;
  logic [NUM_CH-1:0] next_shutFlags;
  logic [2:0] next_alarmRun [NUM_CH];
  logic [2:0] next_shutRun [NUM_CH];
  logic next_alert;
  logic next_therm;
  logic [NUM_CH-1:0] curHigh;
  logic [NUM_CH-1:0] curLow;
  logic [NUM_CH-1:0] curOpen;
  logic [2:0] alarmNeed;
  logic [2:0] shutNeed;

  // address decode of the strobes
  logic wrHyst;
  logic wrConsec;
  logic wrMask;
  logic rdOpen;
  logic rdHigh;
  logic rdLow;
  logic rdShut;

  assign wrHyst = regReq.write && (regReq.addr == ADDR_HYST);
  assign wrConsec = regReq.write && (regReq.addr == ADDR_CONSEC);
  assign wrMask = regReq.write && (regReq.addr == ADDR_MASK);
  assign rdOpen = regReq.read && (regReq.addr == ADDR_OPEN);
  assign rdHigh = regReq.read && (regReq.addr == ADDR_HIGH);
  assign rdLow = regReq.read && (regReq.addr == ADDR_LOW);
  assign rdShut = regReq.read && (regReq.addr == ADDR_SHUT);

  // filter lengths from the two count fields
  // codes outside the four listed ones give popcount plus one
  // [R18] count code decode
  assign alarmNeed = countNeed(consecutiveFaultFilter[ALARM_CNT_LSB +: CNT_W]);
  assign shutNeed = countNeed(consecutiveFaultFilter[SHUT_CNT_LSB +: CNT_W]);

  // hysteresis register, plain unsigned degrees
  // [R1] [R3] [R4] [R5] hysteresis storage
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      shutdownHysteresis <= HYST_RESET;
    else if (wrHyst)
      shutdownHysteresis <= regReq.data;
  end

  // filter register; bits 7 and 0 are not stored
  // [R9] filter register layout
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      consecutiveFaultFilter <= CONSEC_RESET;
    else if (wrConsec)
      consecutiveFaultFilter <= regReq.data & CONSEC_WRITE_MASK;
  end

  // channel mask, one bit per channel from bit 0
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      chanMask <= MASK_RESET[NUM_CH-1:0];
    else if (wrMask)
      chanMask <= regReq.data[NUM_CH-1:0];
  end

  // latest comparator results; a read in the same cycle as a
  // conversion must judge by the new result, not the stale one
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      curHigh[i] = convDone ? chanIn[i].high : lastHigh[i];
      curLow[i] = convDone ? chanIn[i].low : lastLow[i];
      curOpen[i] = (convDone ? chanIn[i].diodeOpen : lastOpen[i]) & OPEN_VALID[i];
    end
  end

  // hold the comparator results between conversions
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lastHigh <= '0;
      lastLow <= '0;
      lastOpen <= '0;
    end
    else
    begin
      lastHigh <= curHigh;
      lastLow <= curLow;
      lastOpen <= curOpen;
    end
  end

  // shutdown comparator with hysteresis, judged once per conversion;
  // the nine-bit sum keeps limit minus hysteresis from wrapping
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      next_shutTrip[i] = shutTrip[i];
      if (convDone)
      begin
        if (chanIn[i].temp > chanIn[i].shutLimit)
          next_shutTrip[i] = 1'b1;
        // [R20] release below limit minus hysteresis
        else if (({1'b0, chanIn[i].temp} + {1'b0, shutdownHysteresis}) < {1'b0, chanIn[i].shutLimit})
          next_shutTrip[i] = 1'b0;
      end
    end
  end

  // trip state, one bit per channel
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      shutTrip <= '0;
    else
      shutTrip <= next_shutTrip;
  end

  // sticky status; a read clears only where the cause has gone,
  // and a new event in the reading cycle still sets the bit
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      // [R10] open flags clear on read
      next_diodeOpenFlags[i] = (rdOpen ? curOpen[i] : diodeOpenFlags[i])
                               | (convDone & chanIn[i].diodeOpen & OPEN_VALID[i]);
      // [R12] high flags clear on read
      next_highFlags[i] = (rdHigh ? curHigh[i] : highFlags[i]) | (convDone & chanIn[i].high);
      // [R14] low flags clear on read
      next_lowFlags[i] = (rdLow ? curLow[i] : lowFlags[i]) | (convDone & chanIn[i].low);
      // [R16] shutdown flag follows the trip
      next_shutFlags[i] = (rdShut ? 1'b0 : shutFlags[i]) | next_shutTrip[i];
    end
  end

  // status registers update on every conversion, unfiltered
  // [R19] status ignores filter
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      diodeOpenFlags <= '0;
      highFlags <= '0;
      lowFlags <= '0;
      shutFlags <= '0;
    end
    else
    begin
      diodeOpenFlags <= next_diodeOpenFlags;
      highFlags <= next_highFlags;
      lowFlags <= next_lowFlags;
      shutFlags <= next_shutFlags;
    end
  end

  // summary flags taken from the next state so they never lag
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      highFlag <= 1'b0;
      lowFlag <= 1'b0;
      thermFlag <= 1'b0;
    end
    else
    begin
      // [R13] summary high OR
      highFlag <= |next_highFlags;
      // [R15] summary low OR
      lowFlag <= |next_lowFlags;
      // [R17] summary shutdown OR
      thermFlag <= |next_shutFlags;
    end
  end

  // consecutive run counters; saturate so long faults cannot wrap
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      next_alarmRun[i] = alarmRun[i];
      next_shutRun[i] = shutRun[i];
      if (convDone)
      begin
        if (chanIn[i].high | chanIn[i].low | (chanIn[i].diodeOpen & OPEN_VALID[i]))
          next_alarmRun[i] = (alarmRun[i] == RUN_MAX) ? RUN_MAX : alarmRun[i] + 3'h1;
        else
          next_alarmRun[i] = RUN_ZERO;
        if (next_shutTrip[i])
          next_shutRun[i] = (shutRun[i] == RUN_MAX) ? RUN_MAX : shutRun[i] + 3'h1;
        else
          next_shutRun[i] = RUN_ZERO;
      end
    end
  end

  // run counters, one pair per channel
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (!reset_n)
      begin
        alarmRun[i] <= RUN_ZERO;
        shutRun[i] <= RUN_ZERO;
      end
      else
      begin
        alarmRun[i] <= next_alarmRun[i];
        shutRun[i] <= next_shutRun[i];
      end
    end
  end

  // output pins assert once a run reaches the chosen length; they move
  // only on a conversion, so a filter or mask write alone never toggles them
  always_comb
  begin
    next_alert = alertActive;
    next_therm = thermActive;
    if (convDone)
    begin
      next_alert = 1'b0;
      next_therm = 1'b0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        // [R11] masked channels drive alert
        if (chanMask[i] && (next_alarmRun[i] >= alarmNeed))
          next_alert = 1'b1;
        // [R18] shutdown filter length
        if (next_shutRun[i] >= shutNeed)
          next_therm = 1'b1;
      end
    end
  end

  // pin registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      alertActive <= 1'b0;
      thermActive <= 1'b0;
    end
    else
    begin
      alertActive <= next_alert;
      thermActive <= next_therm;
    end
  end

  // read port, data one cycle after the strobe; unmapped reads zero
  // status reads return the value held before a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      regRdData <= READ_IDLE;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regReq.read;
      if (regReq.read)
      begin
        case (regReq.addr)
          ADDR_HYST: regRdData <= shutdownHysteresis;
          ADDR_CONSEC: regRdData <= consecutiveFaultFilter;
          // [R6] [R7] [R8] fixed identity reads
          ADDR_MAKER_ID: regRdData <= MAKER_ID;
          ADDR_PART_ID: regRdData <= PART_ID;
          ADDR_OPEN: regRdData <= 8'(diodeOpenFlags);
          ADDR_HIGH: regRdData <= 8'(highFlags);
          ADDR_LOW: regRdData <= 8'(lowFlags);
          ADDR_SHUT: regRdData <= 8'(shutFlags);
          ADDR_MASK: regRdData <= 8'(chanMask);
          default: regRdData <= READ_IDLE;
        endcase
      end
    end
  end

endmodule : tam_status_regs

/* rtl/tam_pkg.sv */
// Overview of operation
// [R1] hold eight-bit hysteresis for shutdown alarm
// [R2] host keeps hysteresis below all limits
// [R3] hysteresis resets to ten degrees always
// [R4] hysteresis is unsigned whole degrees, 0..255
// [R5] hysteresis register at 21h, reset 0Ah
// [R6] FEh reads fixed maker code
// [R7] FDh reads fixed part code per variant
// [R8] identity registers ignore host writes
// [R9] filter register 22h, reset 70h, fields
// [R10] open flags per remote, clear-on-read if gone
// [R11] masked channel drives the alert output
// [R12] high flag per channel, clear-on-read if gone
// [R13] summary high flag ORs channel high flags
// [R14] low flag per channel, clear-on-read if gone
// [R15] summary low flag ORs channel low flags
// [R16] shutdown flag set while channel over limit
// [R17] summary shutdown flag ORs channel flags
// [R18] codes 000,001,011,111 need 1..4 conversions
// [R19] filtering gates pins only, not status
// [R20] shutdown trip releases below limit minus hysteresis
package tam_pkg;

  // pointer addresses
  localparam logic [7:0] ADDR_HYST = 8'h21;
  localparam logic [7:0] ADDR_CONSEC = 8'h22;
  localparam logic [7:0] ADDR_PART_ID = 8'hfd;
  localparam logic [7:0] ADDR_MAKER_ID = 8'hfe;
  localparam logic [7:0] ADDR_OPEN = 8'h35;
  localparam logic [7:0] ADDR_HIGH = 8'h36;
  localparam logic [7:0] ADDR_LOW = 8'h37;
  localparam logic [7:0] ADDR_SHUT = 8'h38;
  localparam logic [7:0] ADDR_MASK = 8'h39;

  // values after reset
  localparam logic [7:0] HYST_RESET = 8'h0a;
  localparam logic [7:0] CONSEC_RESET = 8'h70;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // filter register layout: bits 7 and 0 always zero
  localparam logic [7:0] CONSEC_WRITE_MASK = 8'h7e;
  localparam int SHUT_CNT_LSB = 4;
  localparam int ALARM_CNT_LSB = 1;
  localparam int CNT_W = 3;

  // run counter saturates at the longest filter length
  localparam logic [2:0] RUN_MAX = 3'h4;
  localparam logic [2:0] RUN_ZERO = 3'h0;

  // identity codes; both values are arbitrary
  localparam logic [7:0] MAKER_ID_DEFAULT = 8'h4d;
  localparam logic [7:0] PART_ID_DEFAULT = 8'h07;

  // register access strobe with its address and data
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] data;
  } tam_reg_req_t;

  // one channel's result of the latest conversion
  typedef struct packed {
    logic high;
    logic low;
    logic diodeOpen;
    logic [7:0] temp;
    logic [7:0] shutLimit;
  } tam_chan_t;

endpackage : tam_pkg

/* dv/tam_checker_assertions.sv */
`timescale 1ns/1ps
module tam_checker
  import tam_pkg::*;
#(
  parameter int NUM_CH = 3,
  parameter logic [7:0] MAKER_ID = MAKER_ID_DEFAULT,
  parameter logic [7:0] PART_ID = PART_ID_DEFAULT
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire tam_reg_req_t regReq,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  // conversion port and outputs
  input wire logic convDone,
  input wire tam_chan_t [NUM_CH-1:0] chanIn,
  input wire logic alertActive,
  input wire logic thermActive,
  input wire logic highFlag,
  input wire logic lowFlag,
  input wire logic thermFlag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  rd_answer_a: assert property (regReq.read |=> regRdValid) else $error("read not answered");
  rd_pulse_a: assert property (!regReq.read |=> !regRdValid) else $error("answer without read");
  maker_code_a: assert property (regReq.read && regReq.addr == ADDR_MAKER_ID |=> regRdData == MAKER_ID)
    else $error("maker code wrong");
  part_code_a: assert property (regReq.read && regReq.addr == ADDR_PART_ID |=> regRdData == PART_ID)
    else $error("part code wrong");
  high_sum_a: assert property (convDone && chanIn[1].high |=> highFlag) else $error("high summary missing");
  low_sum_a: assert property (convDone && chanIn[1].low |=> lowFlag) else $error("low summary missing");
  therm_sum_a: assert property (convDone && chanIn[1].temp > chanIn[1].shutLimit |=> thermFlag)
    else $error("shutdown summary missing");
  // a pending high status survives until its own register is read
  flag_sticky_a: assert property (highFlag && !(regReq.read && regReq.addr == ADDR_HIGH) |=> highFlag)
    else $error("high flag dropped");
  therm_moment_a: assert property ($rose(thermActive) |-> $past(convDone))
    else $error("shutdown pin moved without conversion");
  alert_moment_a: assert property ($rose(alertActive) |-> $past(convDone))
    else $error("alert pin moved without conversion");
endmodule : tam_checker

bind tam_status_regs tam_checker #(.NUM_CH(NUM_CH), .MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) i_tam_checker (
  .sys_clk(sys_clk), .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
  .convDone(convDone), .chanIn(chanIn), .alertActive(alertActive), .thermActive(thermActive),
  .highFlag(highFlag), .lowFlag(lowFlag), .thermFlag(thermFlag));

/* dv/tam_host_model.sv */
`timescale 1ns/1ps
module tam_host_model
  import tam_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // register port
  output tam_reg_req_t regReq,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial regReq = '0;
  // one-cycle write strobe; released address and data are inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{write: 1'b1, read: 1'b0, addr: a, data: d};
    @(posedge sys_clk);
    regReq <= '{write: 1'b0, read: 1'b0, addr: ~a, data: ~d};
  endtask : wr
  // one-cycle read strobe, answer taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{write: 1'b0, read: 1'b1, addr: a, data: 8'h00};
    @(posedge sys_clk);
    regReq <= '{write: 1'b0, read: 1'b0, addr: ~a, data: 8'hff};
    #1;
    d = (regRdValid === 1'b1) ? regRdData : 8'hxx; // missing answer shows as unknown
  endtask : rd
endmodule : tam_host_model

/* dv/temp_alarm_status_regs_bench.sv */
`timescale 1ns/1ps
module temp_alarm_status_regs_bench
  import tam_pkg::*;
;
  logic sys_clk;
  logic reset_n;
  tam_reg_req_t regReq;
  logic [7:0] regRdData;
  logic regRdValid;
  logic convDone;
  tam_chan_t [2:0] chanIn;
  logic alertActive, thermActive, highFlag, lowFlag, thermFlag;
  int fails = 0;
  int checksDone = 0;
  int cycles = 0;
  tam_status_regs i_tam_status_regs (.sys_clk(sys_clk), .reset_n(reset_n), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .convDone(convDone), .chanIn(chanIn),
    .alertActive(alertActive), .thermActive(thermActive), .highFlag(highFlag), .lowFlag(lowFlag),
    .thermFlag(thermFlag));
  tam_host_model i_tam_host_model (.sys_clk(sys_clk), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_tam_host_model.rd(a, d);
    chk(d, exp);
  endtask : rdc
  // one conversion, f = high, low, open for channel ch, the other channels clean
  task automatic conv(input int ch, input logic [2:0] f, input logic [7:0] t, input logic [7:0] lim);
    tam_chan_t [2:0] v;
    v = '0;
    v[ch] = '{high: f[2], low: f[1], diodeOpen: f[0], temp: t, shutLimit: lim};
    @(posedge sys_clk);
    convDone <= 1'b1;
    chanIn <= v;
    @(posedge sys_clk);
    convDone <= 1'b0;
    #1;
  endtask : conv
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic t_reset();
    rdc(ADDR_HYST, HYST_RESET);
    rdc(ADDR_CONSEC, CONSEC_RESET);
    rdc(ADDR_MASK, {5'h0, MASK_RESET[2:0]});
    chk({3'h0, alertActive, thermActive, highFlag, lowFlag, thermFlag}, 8'h00);
    $display("test reset done");
  endtask : t_reset
  // write masks, read-only codes, unmapped place
  task automatic t_regs();
    i_tam_host_model.wr(ADDR_HYST, 8'hff);
    rdc(ADDR_HYST, 8'hff);
    i_tam_host_model.wr(ADDR_HYST, 8'h00);
    rdc(ADDR_HYST, 8'h00);
    i_tam_host_model.wr(ADDR_CONSEC, 8'hff);
    rdc(ADDR_CONSEC, 8'h7e);
    i_tam_host_model.wr(ADDR_CONSEC, 8'h81);
    rdc(ADDR_CONSEC, 8'h00);
    i_tam_host_model.wr(ADDR_MAKER_ID, 8'h00);
    i_tam_host_model.wr(ADDR_PART_ID, 8'h00);
    rdc(ADDR_MAKER_ID, MAKER_ID_DEFAULT);
    rdc(ADDR_PART_ID, PART_ID_DEFAULT);
    rdc(8'h40, READ_IDLE);
    $display("test regs done");
  endtask : t_regs
  // clear on read only once the fault has gone
  task automatic t_flags();
    logic [7:0] a;
    logic [7:0] e;
    logic [7:0] s;
    for (int k = 0; k < 3; k++)
    begin
      a = (k == 2) ? ADDR_OPEN : ADDR_HIGH + 8'(k);
      e = (k == 2) ? 8'h04 : 8'h02;
      s = {5'h0, k == 0, k == 1, 1'b0};
      conv((k == 2) ? 2 : 1, 3'b100 >> k, 8'h00, 8'h00);
      chk({5'h0, highFlag, lowFlag, 1'b0}, s);
      rdc(a, e);
      rdc(a, e);
      conv(1, 3'b000, 8'h00, 8'h00);
      chk({5'h0, highFlag, lowFlag, 1'b0}, s);
      rdc(a, e);
      rdc(a, 8'h00);
      chk({5'h0, highFlag, lowFlag, 1'b0}, 8'h00);
    end
    conv(0, 3'b001, 8'h00, 8'h00);
    rdc(ADDR_OPEN, 8'h00);
    $display("test flags done");
  endtask : t_flags
  // four-conversion shutdown filter and hysteresis release
  task automatic t_therm();
    i_tam_host_model.wr(ADDR_CONSEC, CONSEC_RESET);
    i_tam_host_model.wr(ADDR_HYST, 8'h05);
    for (int i = 0; i < 4; i++)
    begin
      conv(1, 3'b000, 8'h3c, 8'h32);
      chk({6'h0, thermActive, thermFlag}, {6'h0, i == 3, 1'b1});
    end
    conv(1, 3'b000, 8'h2e, 8'h32);
    chk({7'h0, thermActive}, 8'h01);
    conv(1, 3'b000, 8'h2d, 8'h32);
    chk({7'h0, thermActive}, 8'h01);
    conv(1, 3'b000, 8'h2c, 8'h32);
    chk({7'h0, thermActive}, 8'h00);
    rdc(ADDR_SHUT, 8'h02);
    rdc(ADDR_SHUT, 8'h00);
    chk({7'h0, thermFlag}, 8'h00);
    $display("test therm done");
  endtask : t_therm
  task automatic t_alert();
    i_tam_host_model.wr(ADDR_CONSEC, 8'h02);
    i_tam_host_model.wr(ADDR_MASK, 8'h00);
    conv(1, 3'b100, 8'h00, 8'h00);
    conv(1, 3'b100, 8'h00, 8'h00);
    chk({6'h0, alertActive, highFlag}, 8'h01);
    conv(1, 3'b000, 8'h00, 8'h00);
    i_tam_host_model.wr(ADDR_MASK, 8'h02);
    conv(1, 3'b100, 8'h00, 8'h00);
    chk({7'h0, alertActive}, 8'h00);
    conv(1, 3'b100, 8'h00, 8'h00);
    chk({7'h0, alertActive}, 8'h01);
    $display("test alert done");
  endtask : t_alert
  // cuts a hang short
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    convDone = 1'b0;
    chanIn = '0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_flags();
    t_therm();
    t_alert();
    stop_test();
  end
endmodule : temp_alarm_status_regs_bench
